// ### core/tos_scheduler.sv
`timescale 1ns/10ps
// Operation
// - A channel's level reaches its pin only while that channel's enable bit is set.
// - When ticker equals head entry's target, apply its bits and remove it.
// - Entries are applied strictly in written order, each discarded once issued.
// - Each image write appends its entries behind waiting ones, up to five per batch, stopping after one whose running number has bit 6 set.
// - The output image is twenty bytes: five entries of four bytes each.
// - Scheduler status is reported to the host through the input image.
module tos_scheduler
  import tos_pkg::*;
#(
  parameter int unsigned QDEPTH = QUEUE_DEPTH,
  parameter int unsigned SDEPTH = STAGE_DEPTH
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  // Output image from the host
  input  wire logic                  image_write,
  input  wire logic [IMAGE_BITS-1:0] output_image,
  output logic                       image_ready,
  // Microsecond ticker from the host
  input  wire logic [15:0]           ticker_us,
  // Output pins
  output logic [1:0]                 dout,
  output logic [1:0]                 dout_enable,
  // Input image to the host
  output tos_input_image_s           input_image
);

  localparam int unsigned QAW = $clog2(QDEPTH);
  localparam int unsigned QCW = $clog2(QDEPTH+1);
  localparam int unsigned BIW = $clog2(ENTRIES_BATCH+1);
  localparam int unsigned SCW = $clog2(SDEPTH+1);

  typedef enum logic [1:0] {
    TOS_IDLE   = 2'b01,
    TOS_UNPACK = 2'b10
  } tos_state_e;

  // Ticker is from the host's domain: three stages before use.
  // A word is taken only when two samples in a row agree, so a sample torn across changing bits is never used.
  logic [15:0] tick_s1_q, tick_s2_q, tick_s3_q;
  logic [15:0] tick_q, tick_d;

  // Batch unpacker.
  tos_state_e                  state_q, state_d;
  logic [IMAGE_BITS-1:0]       batch_q, batch_d;
  logic [BIW-1:0]              idx_q, idx_d;
  tos_timed_output_entry_s     cur_entry;
  logic                        stage_in_valid, stage_in_ready;
  logic                        stage_out_valid, stage_out_ready;
  logic [ENTRY_BITS-1:0]       stage_out_data;
  logic [SCW-1:0]              stage_count;

  // Main queue.
  tos_timed_output_entry_s     queue_q [QDEPTH];
  logic [QAW-1:0]              qwr_q, qwr_d, qrd_q, qrd_d;
  logic [QCW-1:0]              qcnt_q, qcnt_d;
  logic                        qpush, qpop;
  tos_timed_output_entry_s     head;

  // Outputs and status.
  logic [1:0]                  level_q, level_d, en_q, en_d;
  logic [1:0]                  dout_q, dout_d;
  logic [7:0]                  last_rn_q, last_rn_d, next_rn_q, next_rn_d;
  logic                        image_ready_q, image_ready_d;

  assign cur_entry = tos_timed_output_entry_s'(batch_q[IMAGE_BITS-1 -: ENTRY_BITS]);

  always_comb begin
    tick_d = tick_q;
    if (tick_s2_q == tick_s3_q) begin
      tick_d = tick_s2_q;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tick_s1_q <= 16'h0000;
      tick_s2_q <= 16'h0000;
      tick_s3_q <= 16'h0000;
      tick_q    <= 16'h0000;
    end else begin
      tick_s1_q <= ticker_us;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      tick_q    <= tick_d;
    end
  end

  // Unpacker walks the latched batch entry by entry into the stage FIFO.
  always_comb begin
    state_d        = state_q;
    batch_d        = batch_q;
    idx_d          = idx_q;
    stage_in_valid = 1'b0;
    image_ready_d  = 1'b0;
    last_rn_d      = last_rn_q;
    unique case (state_q)
      TOS_IDLE: begin
        image_ready_d = 1'b1;
        if (image_write && image_ready_q) begin
          batch_d       = output_image;
          idx_d         = '0;
          state_d       = TOS_UNPACK;
          image_ready_d = 1'b0;
        end
      end
      TOS_UNPACK: begin
        stage_in_valid = 1'b1;
        if (stage_in_ready) begin
          last_rn_d = cur_entry.running_number;
          batch_d   = batch_q << ENTRY_BITS;
          idx_d     = idx_q + BIW'(1);
          // Stop after five entries or after the marked last one.
          if (idx_q == BIW'(ENTRIES_BATCH-1) || cur_entry.running_number[LAST_FLAG_BIT]) begin
            state_d       = TOS_IDLE;
            image_ready_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q       <= TOS_IDLE;
      batch_q       <= '0;
      idx_q         <= '0;
      image_ready_q <= 1'b0;
      last_rn_q     <= RN_RESET;
    end else begin
      state_q       <= state_d;
      batch_q       <= batch_d;
      idx_q         <= idx_d;
      image_ready_q <= image_ready_d;
      last_rn_q     <= last_rn_d;
    end
  end

  tos_fifo #(
    .WIDTH (ENTRY_BITS),
    .DEPTH (SDEPTH)
  ) u_stage (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_valid  (stage_in_valid),
    .in_ready  (stage_in_ready),
    .in_data   (cur_entry),
    .out_valid (stage_out_valid),
    .out_ready (stage_out_ready),
    .out_data  (stage_out_data),
    .count     (stage_count)
  );

  // Main queue of up to 31 entries, filled in order from the stage FIFO.
  assign stage_out_ready = (qcnt_q != QCW'(QDEPTH));
  assign qpush           = stage_out_valid && stage_out_ready;
  assign head            = queue_q[qrd_q];
  assign qpop            = (qcnt_q != '0) && (tick_q == head.target_microseconds);

  always_comb begin
    qwr_d     = qwr_q;
    qrd_d     = qrd_q;
    qcnt_d    = qcnt_q;
    level_d   = level_q;
    en_d      = en_q;
    next_rn_d = next_rn_q;
    if (qpush) begin
      qwr_d = (qwr_q == QAW'(QDEPTH-1)) ? '0 : qwr_q + QAW'(1);
    end
    if (qpop) begin
      level_d   = {head.control[LEVEL1_BIT], head.control[LEVEL0_BIT]};
      en_d      = {head.control[ENABLE1_BIT], head.control[ENABLE0_BIT]};
      qrd_d     = (qrd_q == QAW'(QDEPTH-1)) ? '0 : qrd_q + QAW'(1);
    end
    if (qcnt_q != '0) begin
      next_rn_d = head.running_number;
    end
    if (qpush && !qpop) begin
      qcnt_d = qcnt_q + QCW'(1);
    end else if (qpop && !qpush) begin
      qcnt_d = qcnt_q - QCW'(1);
    end
    dout_d = level_d & en_d;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      qwr_q     <= '0;
      qrd_q     <= '0;
      qcnt_q    <= '0;
      level_q   <= OUT_RESET;
      en_q      <= OUT_RESET;
      dout_q    <= OUT_RESET;
      next_rn_q <= RN_RESET;
    end else begin
      qwr_q     <= qwr_d;
      qrd_q     <= qrd_d;
      qcnt_q    <= qcnt_d;
      level_q   <= level_d;
      en_q      <= en_d;
      dout_q    <= dout_d;
      next_rn_q <= next_rn_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (qpush) begin
      queue_q[qwr_q] <= tos_timed_output_entry_s'(stage_out_data);
    end
  end

  assign dout        = dout_q;
  assign dout_enable = en_q;
  assign image_ready = image_ready_q;

  // Status for the input image, all registered.
  tos_input_image_s status_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_q <= '0;
    end else begin
      status_q.last_running_number <= last_rn_q;
      status_q.next_running_number <= next_rn_q;
      status_q.queue_count         <= 8'(qcnt_q);
      status_q.queue_full          <= (qcnt_q == QCW'(QDEPTH));
      status_q.stage_full          <= (stage_count == SCW'(SDEPTH));
    end
  end
  assign input_image = status_q;

endmodule : tos_scheduler

// ### core/tos_pkg.sv
package tos_pkg;

  // Entry layout.
  localparam int unsigned ENTRY_BITS     = 32;
  localparam int unsigned ENTRIES_BATCH  = 5;
  localparam int unsigned IMAGE_BITS     = ENTRY_BITS * ENTRIES_BATCH;
  localparam int unsigned QUEUE_DEPTH    = 31;
  localparam int unsigned STAGE_DEPTH    = 8;
  localparam int unsigned LEVEL0_BIT     = 7;
  localparam int unsigned LEVEL1_BIT     = 6;
  localparam int unsigned ENABLE0_BIT    = 5;
  localparam int unsigned ENABLE1_BIT    = 4;
  localparam int unsigned LAST_FLAG_BIT  = 6;
  localparam logic [7:0]  RN_RESET       = 8'h00;
  localparam logic [1:0]  OUT_RESET      = 2'h0;

  typedef struct packed {
    logic [7:0]  control;
    logic [7:0]  running_number;
    logic [15:0] target_microseconds;
  } tos_timed_output_entry_s;

  typedef struct packed {
    logic [7:0] last_running_number;
    logic [7:0] next_running_number;
    logic [7:0] queue_count;
    logic       queue_full;
    logic       stage_full;
  } tos_input_image_s;

endpackage : tos_pkg

// ### core/tos_fifo.sv
`timescale 1ns/10ps
module tos_fifo
  import tos_pkg::*;
#(
  parameter int unsigned WIDTH = ENTRY_BITS,
  parameter int unsigned DEPTH = STAGE_DEPTH
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] count
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0]    cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage carries no reset so it maps to plain RAM.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

endmodule : tos_fifo

// ### testbench/tos_scheduler_monitor.sv
`timescale 1ns/10ps
module tos_scheduler_monitor
  import tos_pkg::*;
#(
  parameter int unsigned QDEPTH = QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  resetn,
  // Host side
  input wire logic                  image_write,
  input wire logic [IMAGE_BITS-1:0] output_image,
  input wire logic                  image_ready,
  input wire logic [15:0]           ticker_us,
  // Pins and status
  input wire logic [1:0]            dout,
  input wire logic [1:0]            dout_enable,
  input wire tos_input_image_s      input_image
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_take;
    image_write && image_ready;
  endsequence

  a_level_needs_enable: assert property ((dout & ~dout_enable) == 2'h0)
    else $error("level driven without enable");
  a_ready_drop_take: assert property (s_take |=> !image_ready)
    else $error("ready stayed high after a batch");
  a_first_ready_up: assert property ($rose(resetn) |=> image_ready)
    else $error("ready not raised after reset");
  a_count_in_bound: assert property (input_image.queue_count <= QDEPTH)
    else $error("queue count above depth");
  a_full_flag_match: assert property (input_image.queue_full == (input_image.queue_count == QDEPTH))
    else $error("full flag disagrees with count");
  a_full_no_grow: assert property ($past(input_image.queue_full) |->
    input_image.queue_count <= $past(input_image.queue_count))
    else $error("count grew while full");
  a_count_one_step: assert property (input_image.queue_count == $past(input_image.queue_count) ||
    input_image.queue_count == $past(input_image.queue_count) + 1 ||
    input_image.queue_count + 1 == $past(input_image.queue_count))
    else $error("count moved by more than one");
  a_pins_need_entry: assert property (!$stable({dout, dout_enable}) |->
    input_image.queue_count != 8'h00)
    else $error("pins changed with empty queue");
endmodule : tos_scheduler_monitor

// ### testbench/tos_host_model.sv
`timescale 1ns/10ps
module tos_host_model
  import tos_pkg::*;
(
  // Clock
  input  wire logic                  mclk,
  // Output image
  output logic                       image_write,
  output logic [IMAGE_BITS-1:0]      output_image,
  input  wire logic                  image_ready,
  // Ticker
  output logic [15:0]                ticker_us
);
  localparam logic [3:0] US_LAST = 4'h9;
  logic       run;
  logic [3:0] div;
  int         stalls;

  initial begin
    image_write  = 1'b0;
    output_image = '0;
    ticker_us    = 16'h0000;
    run          = 1'b0;
    div          = 4'h0;
    stalls       = 0;
  end

  // Ten clocks of 100 ns make one microsecond, so each ticker value stands long enough to settle.
  always @(negedge mclk) begin
    if (run) begin
      if (div == US_LAST) begin
        div       <= 4'h0;
        ticker_us <= ticker_us + 16'h0001;
      end else begin
        div <= div + 4'h1;
      end
    end
  end

  task automatic start(input logic [15:0] t, input logic go);
    @(negedge mclk);
    #1;
    ticker_us = t;
    run       = go;
    div       = 4'h0;
  endtask : start

  task automatic send(input logic [IMAGE_BITS-1:0] img);
    int n;
    @(negedge mclk);
    image_write  = 1'b1;
    output_image = img;
    n = 0;
    while (image_ready !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (image_ready !== 1'b1) begin
      stalls++;
    end
    @(negedge mclk);
    image_write  = 1'b0;
    output_image = ~img;
  endtask : send
endmodule : tos_host_model

// ### testbench/timed_output_scheduler_test.sv
`timescale 1ns/10ps
module timed_output_scheduler_test;
  import tos_pkg::*;
  logic                  mclk;
  logic                  resetn;
  logic                  image_write;
  logic [IMAGE_BITS-1:0] output_image;
  logic                  image_ready;
  logic [15:0]           ticker_us;
  logic [1:0]            dout;
  logic [1:0]            dout_enable;
  tos_input_image_s      input_image;
  int                    n_fail;
  int                    checks;

  tos_scheduler u_tos_scheduler (.mclk(mclk), .resetn(resetn), .image_write(image_write),
    .output_image(output_image), .image_ready(image_ready), .ticker_us(ticker_us), .dout(dout),
    .dout_enable(dout_enable), .input_image(input_image));
  tos_host_model u_tos_host_model (.mclk(mclk), .image_write(image_write), .output_image(output_image),
    .image_ready(image_ready), .ticker_us(ticker_us));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  task automatic wait_tick(input logic [15:0] t);
    int n;
    n = 0;
    while (ticker_us !== t && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (ticker_us !== t) begin
      n_fail++;
    end
  endtask : wait_tick

  // Enable-only entry first, then levels; entry 3 closes the batch so entry 4 is dropped.
  task automatic test_enable_gate();
    logic [7:0] want [4];
    want = '{8'h0C, 8'h0D, 8'h05, 8'h0F};
    check("pins idle", {4'h0, dout_enable, dout}, 8'h00);
    u_tos_host_model.send({8'h30, 8'h01, 16'h0064, 8'hB0, 8'h02, 16'h006E, 8'hE0, 8'h03, 16'h0078,
      8'hF0, 8'h44, 16'h0082, 8'h30, 8'h05, 16'h008C});
    repeat (15) @(negedge mclk);
    check("count", input_image.queue_count, 8'h04);
    check("last rn", input_image.last_running_number, 8'h44);
    check("next rn", input_image.next_running_number, 8'h01);
    u_tos_host_model.start(16'h005A, 1'b1);
    for (int j = 0; j < 4; j++) begin
      wait_tick(16'(106 + 10 * j));
      check("pins", {4'h0, dout_enable, dout}, want[j]);
    end
    wait_tick(16'h0092);
    check("pins dropped", {4'h0, dout_enable, dout}, 8'h0F);
    check("empty", input_image.queue_count, 8'h00);
  endtask : test_enable_gate

  // Forty entries overfill queue and stage, then drain in written order.
  task automatic test_fill_order();
    logic [IMAGE_BITS-1:0] img;
    logic [7:0]            i;
    u_tos_host_model.start(16'h0000, 1'b0);
    for (int b = 0; b < 8; b++) begin
      for (int k = 0; k < 5; k++) begin
        i = 8'(5 * b + k);
        img[IMAGE_BITS-1-32*k -: 32] = {i[0], i[1], 6'h30, i, 16'(200 + 10 * i)};
      end
      u_tos_host_model.send(img);
    end
    repeat (15) @(negedge mclk);
    check("full count", input_image.queue_count, 8'h1F);
    check("full flags", {5'h00, input_image.queue_full, input_image.stage_full, image_ready}, 8'h06);
    u_tos_host_model.start(16'h00BE, 1'b1);
    for (int j = 0; j < 40; j++) begin
      i = 8'(j);
      wait_tick(16'(206 + 10 * j));
      check("order", {4'h0, 2'b11, i[1], i[0]}, {4'h0, dout_enable, dout});
    end
    check("drained", input_image.queue_count, 8'h00);
    check("last rn", input_image.last_running_number, 8'h27);
    check("send stalls", 8'(u_tos_host_model.stalls), 8'h00);
  endtask : test_fill_order

  task automatic test_done();
    if (n_fail == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    #1000us;
    n_fail++;
    test_done();
  end

  initial begin
    n_fail = 0;
    checks = 0;
    resetn = 1'b0;
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    test_enable_gate();
    test_fill_order();
    test_done();
  end
endmodule : timed_output_scheduler_test

bind tos_scheduler tos_scheduler_monitor #(.QDEPTH(QDEPTH)) u_tos_scheduler_monitor (.mclk(mclk),
  .resetn(resetn), .image_write(image_write), .output_image(output_image), .image_ready(image_ready),
  .ticker_us(ticker_us), .dout(dout), .dout_enable(dout_enable), .input_image(input_image));
